// >>> core/tmsc_core.sv
`timescale 1ns/1ns
// Contract
// R1 - Enable low powers every block down; serial port and registers stay alive.
// R2 - Enable high decodes mode field bits 4:2 of main register 0.
// R3 - Clock-output mode drives only reference clock; receive, transmit, LO off.
// R4 - Standby powers PLL, VCO and LO; receive and transmit stay off.
// R5 - Transmit calibration powers transmit, AM detector, I/Q buffers; routes to baseband.
// R6 - RF loopback: front amp off, transmitter into downconverter, all outputs, filter bypass.
// R7 - Baseband loopback routes transmit I/Q to receive filter; only receiver five.
// R8 - Primary reference clock output follows only the enable input.
// R9 - Register bit switches secondary reference output; forced off in shutdown.
// R10 - Entering transmit asserts amplifier bias after a programmed delay.
// R11 - A register bit keeps amplifier bias active in non-transmit modes; the code holds it off in shutdown.
// R12 - Host holds enable high 2 ms before relying on the device.
// R13 - Host writes all registers, then moves mode from 000 to 001.
// R14 - Writing main register 17 starts sub-band acquisition; host waits 2 ms.
// R15 - Host sets highpass corner bit before receive, clears it after settling.
// R16 - Frame is read/write bit, 5 address bits, 10 data bits.
// R17 - Chip select low frames; data sampled on rising serial clock, MSB first.
// R18 - Chip select rising edge loads data into the addressed register.
// R19 - Bit 0 of main register 0 selects main or local space.
// R20 - Select bit 0 means main space, 1 means local space.
// R21 - Registers are not reset; host programs all of them.
// R22 - Read frame shifts register data out on falling serial clock edges.
// R23 - Data output carries lock detect when select is 0, readback when 1.
// R24 - Sixty addressable 10-bit registers across main and local spaces; the code addresses all 64 slots.
// R25 - Read/write polarity of a read frame is a configurable constant.
// R26 - Frames with a clock count other than 16 are ignored.
module tmsc_core (
	input  wire logic                  clk_sys_in,
	input  wire logic                  nrst_in,
	input  wire logic                  enable_in,
	input  wire logic                  pll_lock_in,
	input  wire logic                  sclk_in,
	input  wire logic                  cs_n_in,
	input  wire logic                  din_in,
	output logic                       dout_out,
	output tmsc_pkg::tmsc_blocks_t     blocks_out,
	output logic                       reference_clock_output_en_out,
	output logic                       secondary_reference_output_en_out,
	output logic                       external_amp_bias_output_out,
	output logic                       vco_acq_start_out,
	output logic                       channel_bandwidth_select_out,
	output logic [2:0]                 front_amp_gain_out,
	output logic [1:0]                 front_amp_band_out,
	output logic                       receive_highpass_corner_select_out,
	output logic [7:0]                 mode_out
);

	// ------------------------------------------------------------------
	// Register array, shared by both domains
	// ------------------------------------------------------------------
	logic [tmsc_pkg::DATA_BITS-1:0] regs [tmsc_pkg::REG_SLOTS];

	// ------------------------------------------------------------------
	// Serial clock domain
	// ------------------------------------------------------------------
	logic                                frame_armed;
	logic [tmsc_pkg::CNT_BITS-1:0]       bit_cnt;
	logic [tmsc_pkg::FRAME_BITS-1:0]     shift_in;
	logic [tmsc_pkg::DATA_BITS-1:0]      rd_shift;
	logic [tmsc_pkg::REG_IDX_BITS-1:0]   rd_idx;

	// Cleared while chip select is high so each frame counts from one
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			frame_armed <= 1'b0;
		end else begin
			frame_armed <= 1'b1;
		end
	end

	// Rising-edge count, saturating; holds still while chip select is high
	always_ff @(posedge sclk_in) begin
		if (!cs_n_in) begin
			if (!frame_armed) begin
				bit_cnt <= 5'h01;
			end else if (bit_cnt != 5'h1F) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// Data input shifted MSB first on rising edges
	always_ff @(posedge sclk_in) begin
		if (!cs_n_in) begin
			shift_in <= {shift_in[14:0], din_in}; // R17 R16
		end
	end

	// Read index from space select and the address just received
	assign rd_idx = {regs[0][tmsc_pkg::F_SPACE_SEL], shift_in[4:0]}; // R19 R20

	// Readback loaded after the address, then shifted on falling edges
	always_ff @(negedge sclk_in) begin
		if (!cs_n_in && shift_in[tmsc_pkg::RD_FIRST_EDGE - 1] == tmsc_pkg::READ_LEVEL &&
				bit_cnt == 5'(tmsc_pkg::RD_FIRST_EDGE)) begin
			rd_shift <= regs[rd_idx]; // R22 R25
		end else if (!cs_n_in && bit_cnt > 5'(tmsc_pkg::RD_FIRST_EDGE) &&
				bit_cnt <= 5'(tmsc_pkg::RD_LAST_EDGE)) begin
			rd_shift <= {rd_shift[8:0], 1'b0}; // R22
		end
	end

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic en_meta;
	logic en_sync;
	logic lock_meta;
	logic lock_sync;

	// Two flip-flops for each pin level
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			cs_meta   <= 1'b1;
			cs_sync   <= 1'b1;
			cs_prev   <= 1'b1;
			en_meta   <= 1'b0;
			en_sync   <= 1'b0;
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
		end else begin
			cs_meta   <= cs_n_in;
			cs_sync   <= cs_meta;
			cs_prev   <= cs_sync;
			en_meta   <= enable_in;
			en_sync   <= en_meta;
			lock_meta <= pll_lock_in;
			lock_sync <= lock_meta;
		end
	end

	// ------------------------------------------------------------------
	// Frame commit in the system domain
	// ------------------------------------------------------------------
	tmsc_pkg::tmsc_frame_t               frame;
	logic                                cs_rise;
	logic                                wr_en;
	logic [tmsc_pkg::REG_IDX_BITS-1:0]   wr_idx;
	logic                                main0_written;
	logic                                main14_written;

	// Count and shift register are frozen while chip select is high
	assign frame   = shift_in;
	assign cs_rise = cs_sync & ~cs_prev;
	assign wr_en   = cs_rise && bit_cnt == 5'(tmsc_pkg::FRAME_BITS) &&
			frame.rw != tmsc_pkg::READ_LEVEL; // R18 R26 R25
	assign wr_idx  = {regs[0][tmsc_pkg::F_SPACE_SEL], frame.addr}; // R19 R20

	// Register write; contents have no reset
	always_ff @(posedge clk_sys_in) begin
		if (wr_en) begin
			regs[wr_idx] <= frame.data; // R18 R21 R24
		end
	end

	// Tracks whether the mode and output-select words have been programmed
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			main0_written  <= 1'b0;
			main14_written <= 1'b0;
		end else if (wr_en && wr_idx == {1'b0, tmsc_pkg::ADDR_MODE_BW_SEL}) begin
			main0_written  <= 1'b1;
		end else if (wr_en && wr_idx == {1'b0, tmsc_pkg::ADDR_CLK_DOUT}) begin
			main14_written <= 1'b1;
		end
	end

	// Acquisition start pulse on a write to the last synthesiser word
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			vco_acq_start_out <= 1'b0;
		end else begin
			vco_acq_start_out <= wr_en && wr_idx == {1'b0, tmsc_pkg::ADDR_SYN_FRAC_LO}; // R14
		end
	end

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	tmsc_pkg::tmsc_mode_t mode;
	tmsc_pkg::tmsc_mode_t next_mode;
	logic [2:0]           mode_field;

	assign mode_field = regs[0][tmsc_pkg::F_MODE_LO +: 3];

	// Enable pin overrides the field
	always_comb begin
		if (!en_sync || !main0_written) begin
			next_mode = tmsc_pkg::TMSC_SHUTDOWN; // R1
		end else if (mode_field == 3'h0) begin
			next_mode = tmsc_pkg::TMSC_CLK_ONLY; // R2
		end else if (mode_field == 3'h1) begin
			next_mode = tmsc_pkg::TMSC_STANDBY;
		end else if (mode_field == 3'h2) begin
			next_mode = tmsc_pkg::TMSC_RECEIVE;
		end else if (mode_field == 3'h3) begin
			next_mode = tmsc_pkg::TMSC_TRANSMIT;
		end else if (mode_field == 3'h4) begin
			next_mode = tmsc_pkg::TMSC_TX_CAL;
		end else if (mode_field == 3'h5) begin
			next_mode = tmsc_pkg::TMSC_RF_LOOP;
		end else begin
			next_mode = tmsc_pkg::TMSC_BB_LOOP;
		end
	end

	// Mode state
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			mode <= tmsc_pkg::TMSC_SHUTDOWN;
		end else begin
			mode <= next_mode; // R2
		end
	end

	// ------------------------------------------------------------------
	// Block controls per mode
	// ------------------------------------------------------------------
	tmsc_pkg::tmsc_blocks_t next_blocks;
	logic [4:0]             rx_chan_en;

	assign rx_chan_en = regs[{1'b0, tmsc_pkg::ADDR_RX_CHAN}][4:0];

	// Power and routing for each operating mode; keyed on mode so it lines up with mode_out
	always_comb begin
		next_blocks = '0;
		case (mode)
			tmsc_pkg::TMSC_SHUTDOWN: begin
				next_blocks = '0; // R1
			end
			tmsc_pkg::TMSC_CLK_ONLY: begin
				next_blocks = '0; // R3
			end
			tmsc_pkg::TMSC_STANDBY: begin
				next_blocks.lo_path_on = 1'b1; // R4
			end
			tmsc_pkg::TMSC_RECEIVE: begin
				next_blocks.rx_path_on               = 1'b1;
				next_blocks.lo_path_on               = 1'b1;
				next_blocks.low_noise_front_amp_on   = 1'b1;
				next_blocks.receive_rf_input_on      = 1'b1;
				next_blocks.receive_baseband_outputs = rx_chan_en;
			end
			tmsc_pkg::TMSC_TRANSMIT: begin
				next_blocks.tx_path_on = 1'b1;
				next_blocks.lo_path_on = 1'b1;
			end
			tmsc_pkg::TMSC_TX_CAL: begin
				next_blocks.tx_path_on               = 1'b1; // R5
				next_blocks.lo_path_on               = 1'b1;
				next_blocks.am_detector_on           = 1'b1; // R5
				next_blocks.rx_iq_buffers_on         = 1'b1; // R5
				next_blocks.cal_to_rx_baseband       = 1'b1; // R5
				next_blocks.receive_baseband_outputs = rx_chan_en;
			end
			tmsc_pkg::TMSC_RF_LOOP: begin
				next_blocks.rx_path_on               = 1'b1;
				next_blocks.tx_path_on               = 1'b1;
				next_blocks.lo_path_on               = 1'b1;
				next_blocks.rf_loopback_route        = 1'b1; // R6
				next_blocks.tx_lowpass_bypass        = 1'b1; // R6
				next_blocks.receive_baseband_outputs = 5'h1F; // R6
			end
			tmsc_pkg::TMSC_BB_LOOP: begin
				next_blocks.rx_path_on               = 1'b1;
				next_blocks.lo_path_on               = 1'b1;
				next_blocks.low_noise_front_amp_on   = 1'b1;
				next_blocks.bb_loopback_route        = 1'b1; // R7
				next_blocks.tx_bb_buffer_on          = 1'b1; // R7
				next_blocks.receive_baseband_outputs = 5'h10; // R7
			end
			default: begin
				next_blocks = '0;
			end
		endcase
	end

	// Registered block controls
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			blocks_out <= '0;
		end else begin
			blocks_out <= next_blocks;
		end
	end

	// ------------------------------------------------------------------
	// Reference clock enables
	// ------------------------------------------------------------------
	logic clk2_bit;

	assign clk2_bit = regs[{1'b0, tmsc_pkg::ADDR_CLK_DOUT}][tmsc_pkg::F_CLK2_EN];

	// Primary follows the pin only; secondary also needs its register bit
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			reference_clock_output_en_out     <= 1'b0;
			secondary_reference_output_en_out <= 1'b0;
		end else begin
			reference_clock_output_en_out     <= en_sync; // R8
			secondary_reference_output_en_out <= en_sync && main14_written && clk2_bit; // R9
		end
	end

	// ------------------------------------------------------------------
	// External amplifier bias with programmable delay
	// ------------------------------------------------------------------
	logic [tmsc_pkg::PA_CNT_BITS-1:0] pa_cnt;
	logic [3:0]                       pa_dly;
	logic                             pa_keep;
	logic                             tx_enter;

	assign pa_dly   = regs[{1'b0, tmsc_pkg::ADDR_AMP_BIAS_CTL}][3:0];
	assign pa_keep  = regs[{1'b0, tmsc_pkg::ADDR_AMP_BIAS_CTL}][tmsc_pkg::F_PA_KEEP];
	assign tx_enter = next_mode == tmsc_pkg::TMSC_TRANSMIT &&
			mode != tmsc_pkg::TMSC_TRANSMIT;

	// Delay counter loaded on entry to transmit
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			pa_cnt <= '0;
		end else if (tx_enter) begin
			pa_cnt <= 12'(int'(pa_dly) * tmsc_pkg::PA_STEP_CYC); // R10
		end else if (pa_cnt != '0) begin
			pa_cnt <= pa_cnt - 12'h001;
		end
	end

	// Bias after the delay in transmit, or kept on by register in other modes except shutdown
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			external_amp_bias_output_out <= 1'b0;
		end else if (mode == tmsc_pkg::TMSC_TRANSMIT) begin
			// Waits for mode_out to show transmit, so bias never leads the mode
			external_amp_bias_output_out <= !tx_enter && pa_cnt == '0 &&
					mode_out == tmsc_pkg::TMSC_TRANSMIT &&
					next_mode == tmsc_pkg::TMSC_TRANSMIT; // R10
		end else begin
			external_amp_bias_output_out <= en_sync && main0_written && pa_keep &&
					next_mode != tmsc_pkg::TMSC_TRANSMIT; // R11
		end
	end

	// ------------------------------------------------------------------
	// Static register fields and the mode state driven out
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			channel_bandwidth_select_out       <= 1'b0;
			front_amp_gain_out                 <= 3'h0;
			front_amp_band_out                 <= 2'h0;
			receive_highpass_corner_select_out <= 1'b0;
			mode_out                           <= 8'h01;
		end else begin
			channel_bandwidth_select_out       <= regs[0][tmsc_pkg::F_BW_SEL];
			front_amp_gain_out                 <=
					regs[{1'b0, tmsc_pkg::ADDR_RX_GAIN}][tmsc_pkg::F_FRONT_GAIN +: 3];
			front_amp_band_out                 <=
					regs[{1'b0, tmsc_pkg::ADDR_FRONT_BAND}][tmsc_pkg::F_FRONT_BAND +: 2];
			receive_highpass_corner_select_out <=
					regs[{1'b0, tmsc_pkg::ADDR_RSSI_HP}][tmsc_pkg::F_HP_CORNER];
			mode_out                           <= mode;
		end
	end

	// ------------------------------------------------------------------
	// Data output select
	// ------------------------------------------------------------------
	logic dout_sel;

	assign dout_sel = main14_written &&
			regs[{1'b0, tmsc_pkg::ADDR_CLK_DOUT}][tmsc_pkg::F_DOUT_SEL];
	assign dout_out = dout_sel ? rd_shift[9] : lock_sync; // R23

endmodule : tmsc_core

// >>> inc/tmsc_pkg.sv
package tmsc_pkg;

	// ------------------------------------------------------------------
	// Serial frame layout
	// ------------------------------------------------------------------
	localparam int FRAME_BITS    = 16;
	localparam int ADDR_BITS     = 5;
	localparam int DATA_BITS     = 10;
	localparam int CNT_BITS      = 5;
	localparam int REG_IDX_BITS  = 6;
	localparam int REG_SLOTS     = 64;
	localparam int RD_FIRST_EDGE = 6;
	localparam int RD_LAST_EDGE  = 15;
	localparam logic READ_LEVEL  = 1'b1;

	// ------------------------------------------------------------------
	// Register addresses (main space unless noted)
	// ------------------------------------------------------------------
	localparam logic [4:0] ADDR_MODE_BW_SEL  = 5'h00;
	localparam logic [4:0] ADDR_RX_GAIN      = 5'h01;
	localparam logic [4:0] ADDR_FRONT_BAND   = 5'h02;
	localparam logic [4:0] ADDR_RSSI_HP      = 5'h05;
	localparam logic [4:0] ADDR_RX_CHAN      = 5'h06;
	localparam logic [4:0] ADDR_CLK_DOUT     = 5'h0E;
	localparam logic [4:0] ADDR_SYN_FRAC_LO  = 5'h11;
	localparam logic [4:0] ADDR_AMP_BIAS_CTL = 5'h1C;

	// ------------------------------------------------------------------
	// Recommended values, loaded by the host (no hardware reset)
	// ------------------------------------------------------------------
	localparam logic [9:0] DEF_MODE_BW_SEL = 10'h022;
	localparam logic [9:0] DEF_RX_GAIN     = 10'h0FF;
	localparam logic [9:0] DEF_FRONT_BAND  = 10'h1A0;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int F_SPACE_SEL   = 0;
	localparam int F_BW_SEL      = 1;
	localparam int F_MODE_LO     = 2;
	localparam int F_FRONT_GAIN  = 5;
	localparam int F_FRONT_BAND  = 5;
	localparam int F_HP_CORNER   = 1;
	localparam int F_DOUT_SEL    = 1;
	localparam int F_CLK2_EN     = 9;
	localparam int F_PA_KEEP     = 9;

	// ------------------------------------------------------------------
	// Timing: one step of the amplifier bias delay field
	// ------------------------------------------------------------------
	localparam int CLK_MHZ         = 250;
	localparam int PA_DLY_STEP_NS  = 500;
	localparam int PA_STEP_CYC     = (PA_DLY_STEP_NS * CLK_MHZ) / 1000;
	localparam int PA_CNT_BITS     = 12;

	// Operating mode, one-hot
	typedef enum logic [7:0] {
		TMSC_SHUTDOWN = 8'h01,
		TMSC_CLK_ONLY = 8'h02,
		TMSC_STANDBY  = 8'h04,
		TMSC_RECEIVE  = 8'h08,
		TMSC_TRANSMIT = 8'h10,
		TMSC_TX_CAL   = 8'h20,
		TMSC_RF_LOOP  = 8'h40,
		TMSC_BB_LOOP  = 8'h80
	} tmsc_mode_t;

	// Block power and routing controls
	typedef struct packed {
		logic       rx_path_on;
		logic       tx_path_on;
		logic       lo_path_on;
		logic       low_noise_front_amp_on;
		logic       receive_rf_input_on;
		logic       am_detector_on;
		logic       rx_iq_buffers_on;
		logic       cal_to_rx_baseband;
		logic       rf_loopback_route;
		logic       tx_lowpass_bypass;
		logic       bb_loopback_route;
		logic       tx_bb_buffer_on;
		logic [4:0] receive_baseband_outputs;
	} tmsc_blocks_t;

	// Captured serial frame
	typedef struct packed {
		logic       rw;
		logic [4:0] addr;
		logic [9:0] data;
	} tmsc_frame_t;

endpackage : tmsc_pkg

// >>> verification/tmsc_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host controller driving the serial port
// ------------------------------------------------------------
module tmsc_host_model (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      din_out,
	input  wire logic dout_in
);
	// Idle: clock parked low; a short select pulse clears frame_armed in the unreset frame logic
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b0;
		din_out  = 1'b0;
		#1;
		cs_n_out = 1'b1; // Rising select clears frame_armed so the count restarts at one
	end

	// One framed transfer of nbits clocks; readback gathered before rises 7..16
	task automatic xfer(input logic rw, input logic [4:0] addr, input logic [9:0] data,
			input int nbits, output logic [9:0] rdata);
		logic [15:0] f;
		f = {rw, addr, data};
		rdata = 10'h000;
		cs_n_out = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			din_out = (i < 16) ? f[15 - i] : 1'b0;
			#8;
			if (i >= 6 && i < 16) rdata = {rdata[8:0], dout_in};
			sclk_out = 1'b1;
			#7;
			sclk_out = 1'b0;
		end
		#7;
		cs_n_out = 1'b1;
		din_out  = ~din_out; // Released line shows no stale value
		#60;
	endtask : xfer
endmodule : tmsc_host_model

// >>> verification/tmsc_core_properties.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port-level checks of mode decode, block controls, clock enables, bias control and acquisition start
// ------------------------------------------------------------
module tmsc_core_properties (
	input wire logic                   clk_sys_in,
	input wire logic                   nrst_in,
	input wire logic                   enable_in,
	input wire tmsc_pkg::tmsc_blocks_t blocks_out,
	input wire logic                   reference_clock_output_en_out,
	input wire logic                   secondary_reference_output_en_out,
	input wire logic                   external_amp_bias_output_out,
	input wire logic                   vco_acq_start_out,
	input wire logic [7:0]             mode_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	a_shutdown_all_off: assert property (!enable_in [*6] |-> mode_out == 8'h01 &&
		!blocks_out.rx_path_on && !blocks_out.tx_path_on && !blocks_out.lo_path_on)
		else $error("blocks alive while enable low");
	a_mode_one_hot: assert property ($onehot(mode_out))
		else $error("mode not one-hot");
	a_clkonly_paths_off: assert property ((mode_out == tmsc_pkg::TMSC_CLK_ONLY) [*2] |->
		!blocks_out.rx_path_on && !blocks_out.tx_path_on && !blocks_out.lo_path_on)
		else $error("paths on in clock-output mode");
	a_standby_lo_only: assert property ((mode_out == tmsc_pkg::TMSC_STANDBY) [*2] |->
		blocks_out.lo_path_on && !blocks_out.rx_path_on && !blocks_out.tx_path_on)
		else $error("standby block states wrong");
	a_txcal_blocks: assert property ((mode_out == tmsc_pkg::TMSC_TX_CAL) [*2] |->
		blocks_out.tx_path_on && blocks_out.am_detector_on &&
		blocks_out.rx_iq_buffers_on && blocks_out.cal_to_rx_baseband)
		else $error("transmit calibration blocks wrong");
	a_rfloop_route: assert property ((mode_out == tmsc_pkg::TMSC_RF_LOOP) [*2] |->
		!blocks_out.low_noise_front_amp_on && blocks_out.rf_loopback_route &&
		blocks_out.tx_lowpass_bypass && blocks_out.receive_baseband_outputs == 5'h1F)
		else $error("rf loopback routing wrong");
	a_bbloop_rx5: assert property ((mode_out == tmsc_pkg::TMSC_BB_LOOP) [*2] |->
		blocks_out.bb_loopback_route && blocks_out.receive_baseband_outputs == 5'h10)
		else $error("baseband loopback routing wrong");
	a_refclk_enable: assert property ($stable(enable_in) [*5] |->
		reference_clock_output_en_out == enable_in)
		else $error("reference clock not following enable");
	a_clk2_shutdown: assert property (!enable_in [*5] |->
		!secondary_reference_output_en_out)
		else $error("secondary clock on in shutdown");
	a_bias_after_entry: assert property ($rose(external_amp_bias_output_out) &&
		mode_out == tmsc_pkg::TMSC_TRANSMIT |-> $past(mode_out) == tmsc_pkg::TMSC_TRANSMIT)
		else $error("bias rose at transmit entry without delay");
	a_acq_pulse: assert property (vco_acq_start_out |=> !vco_acq_start_out)
		else $error("acquisition start longer than one cycle");
endmodule : tmsc_core_properties

// >>> verification/testbench.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Self-checking bench for mode control and serial port
// ------------------------------------------------------------
module testbench;
	logic                   clk_sys_in  = 1'b0;
	logic                   nrst_in     = 1'b0;
	logic                   enable_in   = 1'b0;
	logic                   pll_lock_in = 1'b0;
	logic                   sclk, cs_n, din, dout, ref_en, sec_en, bias, acq, bw, hp;
	tmsc_pkg::tmsc_blocks_t blocks;
	logic [2:0]             gain;
	logic [1:0]             band;
	logic [7:0]             mode;
	logic [9:0]             r;
	int                     error_cnt = 0;
	int                     num_checks = 0;
	int                     acq_cnt = 0;
	int                     n;

	// System clock and acquisition pulse counter
	always #2 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (acq === 1'b1) acq_cnt++;

	tmsc_core u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .enable_in(enable_in),
		.pll_lock_in(pll_lock_in), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
		.dout_out(dout), .blocks_out(blocks), .reference_clock_output_en_out(ref_en),
		.secondary_reference_output_en_out(sec_en), .external_amp_bias_output_out(bias),
		.vco_acq_start_out(acq), .channel_bandwidth_select_out(bw),
		.front_amp_gain_out(gain), .front_amp_band_out(band),
		.receive_highpass_corner_select_out(hp), .mode_out(mode));
	tmsc_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [9:0] d);
		logic [9:0] x;
		u_host.xfer(~tmsc_pkg::READ_LEVEL, a, d, 16, x);
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [9:0] d);
		u_host.xfer(tmsc_pkg::READ_LEVEL, a, 10'h000, 16, d);
	endtask : rd
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_in);
		#1;
	endtask : cyc
	function automatic logic [9:0] m0(input logic [2:0] m, input logic sp);
		return {5'h01, m, 1'b1, sp};
	endfunction : m0
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// Watchdog on a hung run
	initial begin
		#100000;
		error_cnt++;
		results();
	end

	// Main sequence
	initial begin
		cyc(4);
		check("mode_rst", mode, 8'h01);
		nrst_in = 1'b1;
		enable_in = 1'b1;
		cyc(20);
		check("ref_en", ref_en, 1'b1);
		check("mode_unwritten", mode, 8'h01);
		// Recommended values, then clock-output to standby
		wr(tmsc_pkg::ADDR_MODE_BW_SEL, tmsc_pkg::DEF_MODE_BW_SEL);
		wr(tmsc_pkg::ADDR_RX_GAIN, tmsc_pkg::DEF_RX_GAIN);
		wr(tmsc_pkg::ADDR_FRONT_BAND, tmsc_pkg::DEF_FRONT_BAND);
		wr(tmsc_pkg::ADDR_CLK_DOUT, 10'h202);
		wr(tmsc_pkg::ADDR_AMP_BIAS_CTL, 10'h000);
		cyc(2);
		check("mode_clkonly", mode, 8'h02);
		check("paths_clkonly", {blocks.rx_path_on, blocks.tx_path_on, blocks.lo_path_on}, 0);
		check("bw", bw, 1'b1);
		check("gain", gain, 3'h7);
		check("band", band, 2'h1);
		check("clk2", sec_en, 1'b1);
		wr(tmsc_pkg::ADDR_MODE_BW_SEL, m0(3'd1, 1'b0));
		$display("test defaults done");
		// Every mode code in turn
		wr(tmsc_pkg::ADDR_RSSI_HP, 10'h002);
		cyc(1);
		check("hp_set", hp, 1'b1);
		for (int m = 0; m < 8; m++) begin
			wr(tmsc_pkg::ADDR_MODE_BW_SEL, m0(m[2:0], 1'b0));
			cyc(1);
			check("mode", mode, 8'h01 << ((m > 5) ? 7 : m + 1));
			check("lo", blocks.lo_path_on, m != 0);
			check("tx", blocks.tx_path_on, m >= 3 && m <= 5);
			check("rx", blocks.rx_path_on, m == 2 || m >= 5);
		end
		wr(tmsc_pkg::ADDR_RSSI_HP, 10'h000);
		cyc(1);
		check("hp_clr", hp, 1'b0);
		$display("test modes done");
		// Bias delay of two steps on entry to transmit, then keep bit
		wr(tmsc_pkg::ADDR_AMP_BIAS_CTL, 10'h002);
		wr(tmsc_pkg::ADDR_MODE_BW_SEL, m0(3'd3, 1'b0));
		cyc(2 * tmsc_pkg::PA_STEP_CYC - 20);
		check("bias_early", bias, 1'b0);
		for (n = 0; n < 40 && bias !== 1'b1; n++) cyc(1);
		check("bias_late", bias, 1'b1);
		wr(tmsc_pkg::ADDR_AMP_BIAS_CTL, 10'h200);
		wr(tmsc_pkg::ADDR_MODE_BW_SEL, m0(3'd1, 1'b0));
		cyc(1);
		check("bias_keep", bias, 1'b1);
		wr(tmsc_pkg::ADDR_AMP_BIAS_CTL, 10'h000);
		cyc(1);
		check("bias_off", bias, 1'b0);
		$display("test bias done");
		// LO programming order; only the last write starts acquisition
		n = acq_cnt;
		wr(5'h0F, 10'h242);
		wr(5'h10, 10'h380);
		check("acq_early", acq_cnt, n);
		wr(tmsc_pkg::ADDR_SYN_FRAC_LO, 10'h000);
		check("acq_start", acq_cnt, n + 1);
		// Short and long frames are dropped
		u_host.xfer(~tmsc_pkg::READ_LEVEL, tmsc_pkg::ADDR_RX_GAIN, 10'h000, 15, r);
		u_host.xfer(~tmsc_pkg::READ_LEVEL, tmsc_pkg::ADDR_RX_GAIN, 10'h000, 17, r);
		cyc(1);
		check("gain_badcount", gain, 3'h7);
		// Readback, then lock detect on the data output
		rd(tmsc_pkg::ADDR_RX_GAIN, r);
		check("rd_gain", r, tmsc_pkg::DEF_RX_GAIN);
		rd(tmsc_pkg::ADDR_FRONT_BAND, r);
		check("rd_band", r, tmsc_pkg::DEF_FRONT_BAND);
		check("rd_nowrite", gain, 3'h7);
		wr(tmsc_pkg::ADDR_CLK_DOUT, 10'h200);
		pll_lock_in = 1'b1;
		cyc(4);
		check("dout_lock1", dout, 1'b1);
		pll_lock_in = 1'b0;
		cyc(4);
		check("dout_lock0", dout, 1'b0);
		wr(tmsc_pkg::ADDR_CLK_DOUT, 10'h202);
		$display("test serial done");
		// Shutdown keeps serial port and registers alive
		enable_in = 1'b0;
		cyc(8);
		check("mode_sd", mode, 8'h01);
		check("ref_sd", ref_en, 1'b0);
		check("clk2_sd", sec_en, 1'b0);
		wr(tmsc_pkg::ADDR_RX_GAIN, 10'h0A0);
		cyc(1);
		check("gain_sd", gain, 3'h5);
		enable_in = 1'b1;
		cyc(8);
		check("mode_back", mode, 8'h04);
		// Local space select: address 1 now reaches the local bank
		wr(tmsc_pkg::ADDR_MODE_BW_SEL, m0(3'd1, 1'b1));
		wr(tmsc_pkg::ADDR_RX_GAIN, 10'h000);
		rd(tmsc_pkg::ADDR_RX_GAIN, r);
		check("local_rd", r, 10'h000);
		check("main_gain", gain, 3'h5);
		$display("test space done");
		results();
	end
endmodule : testbench

bind tmsc_core tmsc_core_properties u_props (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
	.enable_in(enable_in), .blocks_out(blocks_out),
	.reference_clock_output_en_out(reference_clock_output_en_out),
	.secondary_reference_output_en_out(secondary_reference_output_en_out),
	.external_amp_bias_output_out(external_amp_bias_output_out),
	.vco_acq_start_out(vco_acq_start_out), .mode_out(mode_out));
